// [rtl/pms_seq.sv]
// top: test pulse sequencing, sweep stepping, sampling and result store
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pms_seq #(
    parameter int SEP_MAX_CYC = pms_pkg::SEP_MAX_CYC,
    parameter int RES_DEPTH = 64
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register port
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // adc channels, sampled at pin
    input wire logic [38:0] adc_data,
    // current driver, converter strobe and busy
    output logic [15:0] drive_level,
    output logic drive_on,
    output logic adc_strobe,
    output logic busy
);
    localparam int TEST_CYC = pms_pkg::TEST_CYC;

    pms_pkg::pms_state_t state_q;
    logic [31:0] ctrl_q, imin_q, imax_q, steps_q, width_q, sep_q, avg_q, therm_q;
    logic [31:0] plat_pct_q, vwin_q, safe_q, plat_q;
    logic [2:0] err_q;
    logic abort_q;
    logic [38:0] adc_m_q, adc_s_q;
    pms_pkg::pms_sample_t smp;
    logic [12:0] off_v_q, off_i_q, off_l_q, safe_v_q;
    logic [31:0] tmr_q;
    logic [15:0] step_q, rep_q, therm_cnt_q;
    logic [4:0] div_q;
    logic [6:0] div_cnt_q;
    logic [15:0] scnt_q;
    logic meas_q, clr_q;
    logic [31:0] sum_v, sum_i, sum_l;
    logic [15:0] cnt_v;
    logic [38:0] res_mem_q [RES_DEPTH];
    logic [15:0] res_wr_q, res_rd_q;
    logic [15:0] dl_q;
    logic don_q, strb_q;
    logic [31:0] rd_q;

    // pins pass two flops before use
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            adc_m_q <= 39'h0;
            adc_s_q <= 39'h0;
        end else begin
            adc_m_q <= adc_data;
            adc_s_q <= adc_m_q;
        end
    end
    assign smp = adc_s_q;

    // smallest divider whose samples fit 2000 per pulse plus edges
    function automatic logic [4:0] pick_div(input logic [31:0] w);
        logic [4:0] d;
        d = 5'h14;
        for (int n = pms_pkg::DIV_MAX; n >= 1; n--) begin
            if ((w / (n * 5)) <= 32'(pms_pkg::MAX_SAMPLES)) d = 5'(n);
        end
        return d;
    endfunction

    // samples per pulse including the edge samples
    function automatic logic [31:0] pulse_samples(input logic [31:0] w, input logic [4:0] d);
        return w / ({27'h0, d} * 32'h5) + 32'(2 * pms_pkg::EDGE_SAMPLES);
    endfunction

    logic [31:0] scope_bytes;
    assign scope_bytes = pulse_samples(width_q, pick_div(width_q)) * 32'(pms_pkg::BYTES_PER_SET)
                         * steps_q * avg_q;

    // register writes; start is one shot, abort is held until the sequence is back in idle
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl_q <= 32'h0; imin_q <= 32'h0; imax_q <= 32'h0; steps_q <= 32'h1;
            width_q <= 32'h3e8; sep_q <= 32'h2710; avg_q <= 32'h1; therm_q <= 32'h1;
            plat_pct_q <= 32'h0; vwin_q <= 32'hffff_0000; safe_q <= 32'hffff_ffff;
            plat_q <= 32'h0;
            abort_q <= 1'b0;
        end else begin
            ctrl_q[pms_pkg::CTRL_START] <= 1'b0;
            if (state_q == pms_pkg::ST_IDLE) abort_q <= 1'b0;
            // a stale plateau verdict must not decide the next run
            if (state_q == pms_pkg::ST_IDLE && ctrl_q[pms_pkg::CTRL_START]) plat_q[31:30] <= 2'h0;
            if (reg_wr) begin
                case (reg_addr)
                    pms_pkg::REG_CTRL: begin
                        ctrl_q <= reg_wdata;
                        if (reg_wdata[pms_pkg::CTRL_ABORT]) abort_q <= 1'b1;
                    end
                    pms_pkg::REG_IMIN: imin_q <= reg_wdata;
                    pms_pkg::REG_IMAX: imax_q <= reg_wdata;
                    pms_pkg::REG_STEPS: steps_q <= reg_wdata;
                    pms_pkg::REG_WIDTH: width_q <= reg_wdata;
                    pms_pkg::REG_SEP: sep_q <= (reg_wdata > 32'(SEP_MAX_CYC)) ?
                                               32'(SEP_MAX_CYC) : reg_wdata;
                    pms_pkg::REG_AVG: avg_q <= (reg_wdata > 32'(pms_pkg::AVG_MAX)) ?
                                               32'(pms_pkg::AVG_MAX) : reg_wdata;
                    pms_pkg::REG_THERM: therm_q <= (reg_wdata > 32'(pms_pkg::THERM_MAX)) ?
                                                   32'(pms_pkg::THERM_MAX) : reg_wdata;
                    pms_pkg::REG_PLAT_PCT: plat_pct_q <= reg_wdata;
                    pms_pkg::REG_VWIN: vwin_q <= reg_wdata;
                    pms_pkg::REG_SAFE: safe_q <= reg_wdata;
                    pms_pkg::REG_PLAT: plat_q <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    logic scope;
    logic [1:0] avg_mode;
    assign scope = ctrl_q[pms_pkg::CTRL_SCOPE];
    assign avg_mode = ctrl_q[pms_pkg::CTRL_AVG_LO +: 2];

    // current of the present step, equal increments
    logic [31:0] step_curr;
    assign step_curr = (steps_q <= 32'h1) ? imin_q :
        imin_q + ((imax_q - imin_q) * {16'h0, step_q}) / (steps_q - 32'h1);

    logic tmr_end;
    assign tmr_end = (tmr_q == 32'h0);
    logic [31:0] pulse_len;
    assign pulse_len = width_q + 32'(2 * pms_pkg::EDGE_SAMPLES) * {27'h0, div_q} * 32'h5;

    // main sequence
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_q <= pms_pkg::ST_IDLE;
            err_q <= pms_pkg::ERR_NONE;
            tmr_q <= 32'h0;
            step_q <= 16'h0; rep_q <= 16'h0; therm_cnt_q <= 16'h0;
            div_q <= 5'h1;
            off_v_q <= 13'h0; off_i_q <= 13'h0; off_l_q <= 13'h0; safe_v_q <= 13'h0;
        end else begin
            if (!tmr_end) tmr_q <= tmr_q - 32'h1;
            case (state_q)
                pms_pkg::ST_IDLE: if (ctrl_q[pms_pkg::CTRL_START]) begin
                    div_q <= pick_div(width_q);
                    if (scope && scope_bytes > 32'(pms_pkg::STORE_BYTES)) begin
                        err_q <= pms_pkg::ERR_MEMORY;
                    end else begin
                        err_q <= pms_pkg::ERR_NONE;
                        tmr_q <= 32'(TEST_CYC);
                        state_q <= pms_pkg::ST_OFFSET;
                    end
                end
                pms_pkg::ST_OFFSET: if (tmr_end) begin
                    off_v_q <= smp.volt; off_i_q <= smp.curr; off_l_q <= smp.light;
                    tmr_q <= 32'(TEST_CYC);
                    state_q <= scope ? pms_pkg::ST_SAFE : pms_pkg::ST_CONTACT;
                end
                pms_pkg::ST_CONTACT: if (tmr_end) begin
                    if (smp.volt < vwin_q[12:0] || smp.volt > vwin_q[28:16]) begin
                        err_q <= pms_pkg::ERR_CONTACT;
                        state_q <= pms_pkg::ST_IDLE;
                    end else begin
                        tmr_q <= 32'(TEST_CYC);
                        state_q <= pms_pkg::ST_SAFE;
                    end
                end
                pms_pkg::ST_SAFE: if (tmr_end) begin
                    safe_v_q <= smp.volt;
                    if (width_q > {16'h0, safe_q[15:0]}) begin
                        err_q <= pms_pkg::ERR_WIDTH;
                        state_q <= pms_pkg::ST_IDLE;
                    end else if (width_q * 32'h64 > (width_q + sep_q) * {24'h0, safe_q[23:16]}) begin
                        err_q <= pms_pkg::ERR_DUTY;
                        state_q <= pms_pkg::ST_IDLE;
                    end else begin
                        tmr_q <= scope ? 32'(TEST_CYC) : width_q;
                        state_q <= scope ? pms_pkg::ST_ZERO : pms_pkg::ST_PLATEAU;
                    end
                end
                pms_pkg::ST_PLATEAU: if (tmr_end) state_q <= pms_pkg::ST_PLAT_WAIT;
                pms_pkg::ST_PLAT_WAIT: if (plat_q[31]) begin
                    if (plat_q[30]) begin
                        err_q <= pms_pkg::ERR_PLATEAU;
                        state_q <= pms_pkg::ST_IDLE;
                    end else begin
                        tmr_q <= 32'(TEST_CYC);
                        state_q <= pms_pkg::ST_ZERO;
                    end
                end
                pms_pkg::ST_ZERO: if (tmr_end) begin
                    off_v_q <= smp.volt; off_i_q <= smp.curr; off_l_q <= smp.light;
                    step_q <= 16'h0; rep_q <= 16'h0; therm_cnt_q <= 16'h0;
                    tmr_q <= pulse_len;
                    state_q <= pms_pkg::ST_PULSE;
                end
                pms_pkg::ST_PULSE: if (tmr_end) begin
                    tmr_q <= sep_q;
                    state_q <= pms_pkg::ST_SEP;
                end
                pms_pkg::ST_SEP: if (tmr_end) begin
                    if (abort_q) begin
                        err_q <= pms_pkg::ERR_ABORT;
                        state_q <= pms_pkg::ST_IDLE;
                    end else if ({16'h0, therm_cnt_q} < therm_q) begin
                        therm_cnt_q <= therm_cnt_q + 16'h1;
                        tmr_q <= pulse_len;
                        state_q <= pms_pkg::ST_PULSE;
                    end else if ({16'h0, rep_q} + 32'h1 < avg_q && avg_mode != pms_pkg::AVG_NONE) begin
                        rep_q <= rep_q + 16'h1;
                        tmr_q <= pulse_len;
                        state_q <= pms_pkg::ST_PULSE;
                    end else if ({16'h0, step_q} + 32'h1 < steps_q) begin
                        step_q <= step_q + 16'h1;
                        rep_q <= 16'h0;
                        therm_cnt_q <= 16'h0;
                        tmr_q <= pulse_len;
                        state_q <= pms_pkg::ST_PULSE;
                    end else begin
                        state_q <= pms_pkg::ST_DONE;
                    end
                end
                pms_pkg::ST_DONE: state_q <= pms_pkg::ST_IDLE;
                default: state_q <= pms_pkg::ST_IDLE;
            endcase
        end
    end

    logic measuring;
    assign measuring = (state_q == pms_pkg::ST_PULSE) && ({16'h0, therm_cnt_q} >= therm_q);

    // sample strobe from divider, only inside pulse window and edges
    always_ff @(posedge sys_clk) begin
        if (!reset_n || state_q != pms_pkg::ST_PULSE) begin
            div_cnt_q <= 7'h0;
            scnt_q <= 16'h0;
            strb_q <= 1'b0;
        end else begin
            strb_q <= 1'b0;
            // period of up to 100 cycles at the slowest rate needs seven bits
            if (div_cnt_q >= {2'h0, div_q} * 7'h5 - 7'h1) begin
                div_cnt_q <= 7'h0;
                strb_q <= 1'b1;
                scnt_q <= scnt_q + 16'h1;
            end else begin
                div_cnt_q <= div_cnt_q + 7'h1;
            end
        end
    end

    // outside scope mode only samples inside the plateau window feed the averages
    logic in_plat;
    assign in_plat = scope || (scnt_q >= plat_q[14:0] && scnt_q <= {1'b0, plat_q[29:15]});
    assign meas_q = strb_q && measuring && in_plat;
    // a step closes after its last measured pulse, never after a thermal one
    assign clr_q = (state_q == pms_pkg::ST_ZERO) ||
        (state_q == pms_pkg::ST_SEP && tmr_end && !scope && {16'h0, therm_cnt_q} >= therm_q &&
         (avg_mode == pms_pkg::AVG_NONE || {16'h0, rep_q} + 32'h1 >= avg_q));

    pms_avg u_avg_v (.sys_clk(sys_clk), .reset_n(reset_n), .clear(clr_q), .add(meas_q),
        .offset(off_v_q), .sample(smp.volt), .sum_q(sum_v), .cnt_q(cnt_v));
    pms_avg u_avg_i (.sys_clk(sys_clk), .reset_n(reset_n), .clear(clr_q), .add(meas_q),
        .offset(off_i_q), .sample(smp.curr), .sum_q(sum_i), .cnt_q());
    pms_avg u_avg_l (.sys_clk(sys_clk), .reset_n(reset_n), .clear(clr_q), .add(meas_q),
        .offset(off_l_q), .sample(smp.light), .sum_q(sum_l), .cnt_q());

    function automatic logic [12:0] mean(input logic [31:0] s, input logic [15:0] c);
        return (c == 16'h0) ? 13'h0 : 13'(s / {16'h0, c});
    endfunction

    // result store: averages per step, or raw corrected samples in scope mode
    always_ff @(posedge sys_clk) begin
        if (!reset_n || (state_q == pms_pkg::ST_IDLE && ctrl_q[pms_pkg::CTRL_START])) begin
            res_wr_q <= 16'h0;
        end else if (scope && meas_q && res_wr_q < 16'(RES_DEPTH)) begin
            res_mem_q[res_wr_q[5:0]] <= {smp.volt - off_v_q, smp.curr - off_i_q,
                                         smp.light - off_l_q};
            res_wr_q <= res_wr_q + 16'h1;
        end else if (!scope && clr_q && state_q == pms_pkg::ST_SEP && res_wr_q < 16'(RES_DEPTH)) begin
            res_mem_q[res_wr_q[5:0]] <= {mean(sum_v, cnt_v), mean(sum_i, cnt_v),
                                         mean(sum_l, cnt_v)};
            res_wr_q <= res_wr_q + 16'h1;
        end
    end

    // read pointer advances on each result read in idle until it meets the write pointer
    always_ff @(posedge sys_clk) begin
        if (!reset_n || state_q != pms_pkg::ST_IDLE) begin
            res_rd_q <= 16'h0;
        end else if (reg_rd && reg_addr == pms_pkg::REG_RESULT && res_rd_q < res_wr_q) begin
            res_rd_q <= res_rd_q + 16'h1;
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rd_q <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                pms_pkg::REG_CTRL: rd_q <= ctrl_q;
                pms_pkg::REG_STATUS: rd_q <= {16'h0, safe_v_q[7:0], 1'b0, err_q, state_q};
                pms_pkg::REG_IMIN: rd_q <= imin_q;
                pms_pkg::REG_IMAX: rd_q <= imax_q;
                pms_pkg::REG_STEPS: rd_q <= steps_q;
                pms_pkg::REG_WIDTH: rd_q <= width_q;
                pms_pkg::REG_SEP: rd_q <= sep_q;
                pms_pkg::REG_AVG: rd_q <= avg_q;
                pms_pkg::REG_THERM: rd_q <= therm_q;
                pms_pkg::REG_PLAT_PCT: rd_q <= plat_pct_q;
                pms_pkg::REG_VWIN: rd_q <= vwin_q;
                pms_pkg::REG_SAFE: rd_q <= safe_q;
                pms_pkg::REG_RATE: rd_q <= {27'h0, div_q};
                pms_pkg::REG_PLAT: rd_q <= plat_q;
                pms_pkg::REG_RESULT: rd_q <= (res_rd_q < res_wr_q) ?
                    {6'h0, res_mem_q[res_rd_q[5:0]][38:26], res_mem_q[res_rd_q[5:0]][12:0]} : 32'h0;
                pms_pkg::REG_RES_CNT: rd_q <= {res_rd_q, res_wr_q};
                default: rd_q <= 32'h0;
            endcase
        end else begin
            rd_q <= 32'h0;
        end
    end

    // driver level per phase; off in a phase's last cycle so back to back pulses stay apart
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dl_q <= 16'h0;
            don_q <= 1'b0;
        end else begin
            case (state_q)
                pms_pkg::ST_OFFSET, pms_pkg::ST_SAFE, pms_pkg::ST_ZERO: begin
                    dl_q <= 16'h0; don_q <= !tmr_end;
                end
                pms_pkg::ST_CONTACT: begin
                    dl_q <= 16'(imax_q / {16'h0, pms_pkg::CONTACT_DIV}); don_q <= !tmr_end;
                end
                pms_pkg::ST_PLATEAU: begin
                    dl_q <= 16'((imax_q * plat_pct_q) / 32'h64); don_q <= !tmr_end;
                end
                pms_pkg::ST_PULSE: begin
                    dl_q <= step_curr[15:0]; don_q <= !tmr_end;
                end
                default: begin
                    dl_q <= 16'h0; don_q <= 1'b0;
                end
            endcase
        end
    end

    assign reg_rdata = rd_q;
    assign drive_level = dl_q;
    assign drive_on = don_q;
    assign adc_strobe = strb_q;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) busy <= 1'b0;
        else busy <= (state_q != pms_pkg::ST_IDLE);
    end
endmodule

// [rtl/pms_pkg.sv]
// package: constants, states and carriers for the pulse measurement sequencer
package pms_pkg;
    localparam int CLK_MHZ = 100;
    localparam int TEST_US = 10;
    localparam int TEST_CYC = TEST_US * CLK_MHZ;
    localparam int SEP_MAX_MS = 500;
    localparam int SEP_MAX_CYC = SEP_MAX_MS * 1000 * CLK_MHZ;
    localparam int MAX_SAMPLES = 2000;
    localparam int EDGE_SAMPLES = 4;
    localparam int DIV_MAX = 20;
    localparam int STORE_BYTES = 512 * 1024;
    localparam int BYTES_PER_SET = 6;
    localparam int AVG_MAX = 250;
    localparam int THERM_MAX = 65000;
    localparam logic [15:0] CONTACT_DIV = 16'h0320; // 1/800 = 0.125 percent
    // register offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_IMIN = 5'h02;
    localparam logic [4:0] REG_IMAX = 5'h03;
    localparam logic [4:0] REG_STEPS = 5'h04;
    localparam logic [4:0] REG_WIDTH = 5'h05;
    localparam logic [4:0] REG_SEP = 5'h06;
    localparam logic [4:0] REG_AVG = 5'h07;
    localparam logic [4:0] REG_THERM = 5'h08;
    localparam logic [4:0] REG_PLAT_PCT = 5'h09;
    localparam logic [4:0] REG_VWIN = 5'h0a;
    localparam logic [4:0] REG_SAFE = 5'h0b;
    localparam logic [4:0] REG_RATE = 5'h0c;
    localparam logic [4:0] REG_PLAT = 5'h0d;
    localparam logic [4:0] REG_RESULT = 5'h0e;
    localparam logic [4:0] REG_RES_CNT = 5'h0f;
    // ctrl bits
    localparam int CTRL_START = 0;
    localparam int CTRL_ABORT = 1;
    localparam int CTRL_SCOPE = 2;
    localparam int CTRL_AVG_LO = 3;
    // error codes
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_CONTACT = 3'h1;
    localparam logic [2:0] ERR_WIDTH = 3'h2;
    localparam logic [2:0] ERR_DUTY = 3'h3;
    localparam logic [2:0] ERR_MEMORY = 3'h4;
    localparam logic [2:0] ERR_PLATEAU = 3'h5;
    localparam logic [2:0] ERR_ABORT = 3'h6;
    localparam logic [1:0] AVG_NONE = 2'h0;
    localparam logic [1:0] AVG_PAR = 2'h1;
    localparam logic [1:0] AVG_SER = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_OFFSET = 4'h1,
        ST_CONTACT = 4'h2,
        ST_SAFE = 4'h3,
        ST_PLATEAU = 4'h4,
        ST_PLAT_WAIT = 4'h5,
        ST_ZERO = 4'h6,
        ST_PULSE = 4'h7,
        ST_SEP = 4'h8,
        ST_DONE = 4'h9
    } pms_state_t;

    // one simultaneous sample of all three channels
    typedef struct packed {
        logic [12:0] volt;
        logic [12:0] curr;
        logic [12:0] light;
    } pms_sample_t;
endpackage

// [rtl/pms_avg.sv]
// per channel offset subtracting accumulator
`timescale 1ns/1ps
module pms_avg (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // control
    input wire logic clear,
    input wire logic add,
    input wire logic [12:0] offset,
    input wire logic [12:0] sample,
    // result
    output logic [31:0] sum_q,
    output logic [15:0] cnt_q
);
    logic [13:0] diff;
    assign diff = {1'b0, sample} - {1'b0, offset};

    // accumulate offset corrected samples; negative results clamp to zero
    always_ff @(posedge sys_clk) begin
        if (!reset_n || clear) begin
            sum_q <= 32'h0;
            cnt_q <= 16'h0;
        end else if (add) begin
            sum_q <= sum_q + (diff[13] ? 32'h0 : {19'h0, diff[12:0]});
            cnt_q <= cnt_q + 16'h1;
        end
    end
endmodule

// [dv/pms_seq_asserts.sv]
// checker for the sequencer ports
`timescale 1ns/1ps
module pms_seq_chk #(parameter int SEP_MAX_CYC = 1, parameter int RES_DEPTH = 1) (
    // all ports of the sequencer
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [38:0] adc_data,
    input wire logic [15:0] drive_level,
    input wire logic drive_on,
    input wire logic adc_strobe,
    input wire logic busy
);
    logic go, go_any;
    // start request while idle; scope starts may be refused for storage, so go skips them
    assign go_any = reg_wr && reg_addr == pms_pkg::REG_CTRL && reg_wdata[0] && !busy;
    assign go = go_any && !reg_wdata[pms_pkg::CTRL_SCOPE];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_start_zero: assert property (go |-> ##3 (drive_on && drive_level == 16'h0) [*8])
        else $error("offset pulse not zero");
    a_start_busy: assert property (go |-> ##3 busy)
        else $error("start missed");
    a_busy_cause: assert property ($rose(busy) |-> $past(go_any, 3))
        else $error("busy without start");
    a_idle_quiet: assert property (!busy |-> !drive_on && !adc_strobe)
        else $error("driver active while idle");
    a_level_steady: assert property (drive_on && $past(drive_on) |-> $stable(drive_level))
        else $error("level moved in pulse");
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("data without read");
    a_unmapped_zero: assert property (reg_rd && reg_addr > 5'h0f |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_status_idle: assert property (reg_rd && !busy &&
        reg_addr == pms_pkg::REG_STATUS |=> reg_rdata[3:0] == 4'h0)
        else $error("idle status wrong");
endmodule
bind pms_seq pms_seq_chk #(.SEP_MAX_CYC(SEP_MAX_CYC), .RES_DEPTH(RES_DEPTH)) chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_data(adc_data),
    .drive_level(drive_level), .drive_on(drive_on), .adc_strobe(adc_strobe), .busy(busy));

// [dv/pms_adc_model.sv]
// converter front end: dut voltage, driven current and light
`timescale 1ns/1ps
module pms_adc_model (
    // clock and driver side
    input wire logic sys_clk,
    input wire logic [15:0] drive_level,
    input wire logic drive_on,
    // converter outputs
    output pms_pkg::pms_sample_t adc_data = '0
);
    // all three channels move together; light between pulses is noise, not a held value
    always @(posedge sys_clk) begin
        adc_data.volt <= (drive_on && drive_level != 16'h0) ? 13'h07d0 : 13'h0005;
        adc_data.curr <= drive_on ? drive_level[12:0] : 13'h0000;
        adc_data.light <= drive_on ? drive_level[13:1] : ~adc_data.light;
    end
endmodule

// [dv/pms_seq_tb.sv]
// self-checking bench for the pulse measurement sequencer
`timescale 1ns/1ps
module pms_seq_tb;
    localparam logic [31:0] SF_OK = 32'h005a_03e8;
    localparam logic [31:0] VW_OK = 32'h0bb8_03e8;
    localparam int TC = pms_pkg::TEST_CYC;
    // sweep pulse: width 200 plus edge samples at the fastest rate
    localparam int PL = 200 + 2 * pms_pkg::EDGE_SAMPLES * 5;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] reg_addr = 5'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic [38:0] adc_data;
    logic [15:0] drive_level;
    logic drive_on, adc_strobe, busy;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int strobes = 0;
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    pms_seq #(.SEP_MAX_CYC(1000)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .adc_data(adc_data), .drive_level(drive_level),
        .drive_on(drive_on), .adc_strobe(adc_strobe), .busy(busy));
    pms_adc_model adc (.sys_clk(sys_clk), .drive_level(drive_level), .drive_on(drive_on),
        .adc_data(adc_data));
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // hang guard far above the longest run; also counts converter strobes
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        strobes <= strobes + int'(adc_strobe === 1'b1);
        if (cyc == 90000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(logic [4:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // next pulse: level at its first cycle, then its length
    task automatic pulse(logic [15:0] lvl, int len);
        int n;
        n = 0;
        #1 while (drive_on !== 1'b1 && n < 20000) @(posedge sys_clk) #1 n++;
        cmp(32'(drive_level), 32'(lvl));
        n = 0;
        while (drive_on === 1'b1 && n < 70000) @(posedge sys_clk) #1 n++;
        cmp(32'(n), 32'(len));
    endtask
    task automatic fin(logic [2:0] e);
        int n;
        n = 0;
        // a start needs three edges to show on busy
        repeat (3) @(posedge sys_clk);
        while (busy !== 1'b0 && n < 30000) @(posedge sys_clk) #1 n++;
        rd(pms_pkg::REG_STATUS);
        cmp({25'h0, rv[6:0]}, {25'h0, e, 4'h0});
    endtask
    // upload the settings at offsets 2 to 12, then the control word
    task automatic run(logic [31:0] st, logic [31:0] sf, logic [31:0] vw, logic [31:0] c);
        logic [31:0] v[2:12];
        v = '{32'h64, 32'h1f40, st, 32'hc8, 32'h12c, 32'h1, 32'h1, 32'h32, vw, sf, 32'h5};
        for (int a = 2; a <= 12; a++) wr(5'(a), v[a]);
        wr(pms_pkg::REG_CTRL, c);
    endtask
    // offset, contact at max/800, area, plateau at half of max
    task automatic lead_in();
        pulse(16'h0, TC);
        pulse(16'h000a, TC);
        pulse(16'h0, TC);
        pulse(16'h0fa0, 200);
    endtask
    task automatic t_plateau();
        run(32'h2, SF_OK, VW_OK, 32'h1);
        lead_in();
        wr(pms_pkg::REG_PLAT, 32'hc000_0000);
        fin(pms_pkg::ERR_PLATEAU);
    endtask
    task automatic t_scope_width();
        run(32'h2, 32'h005a_0064, VW_OK, 32'h5);
        pulse(16'h0, TC);
        pulse(16'h0, TC);
        fin(pms_pkg::ERR_WIDTH);
    endtask
    task automatic t_abort();
        run(32'h8, SF_OK, VW_OK, 32'h1);
        lead_in();
        wr(pms_pkg::REG_PLAT, 32'h8000_0000);
        pulse(16'h0, TC);
        wr(pms_pkg::REG_CTRL, 32'h2);
        fin(pms_pkg::ERR_ABORT);
    endtask
    // every averaging mode runs to the end cleanly
    task automatic t_full();
        for (int m = 0; m < 3; m++) begin
            run(32'h2, SF_OK, VW_OK, {27'h0, 2'(m), 3'h1});
            lead_in();
            wr(pms_pkg::REG_PLAT, 32'h8000_0000);
            pulse(16'h0, TC);
            pulse(16'h0064, PL);
            pulse(16'h0064, PL);
            pulse(16'h1f40, PL);
            fin(pms_pkg::ERR_NONE);
            rd(pms_pkg::REG_RES_CNT);
            cmp(rv, 32'h0000_0002);
        end
        cmp(32'(strobes != 0), 32'h1);
        rd(5'h1f);
        cmp(rv, 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_plateau();
        run(32'h2, SF_OK, 32'h0bb8_0bb0, 32'h1);
        fin(pms_pkg::ERR_CONTACT);
        t_scope_width();
        run(32'h2, 32'h001e_03e8, VW_OK, 32'h1);
        fin(pms_pkg::ERR_DUTY);
        run(32'hffff, SF_OK, VW_OK, 32'h5);
        fin(pms_pkg::ERR_MEMORY);
        t_abort();
        t_full();
        end_sim();
    end
endmodule
